// *** design/tdl_pkg.sv ***
package tdl_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS              = 25;
	localparam int HIGH_TURN_ON_DELAY_NS      = 25;
	localparam int LOW_TURN_ON_DELAY_NS       = 12;
	localparam int ZERO_CURRENT_BLANK_TIME_NS = 250;
	localparam int DEBOUNCE_NS                = 80;
	localparam int CAL_TIME_NS                = 25000;
	localparam int TMR_W                      = 16;

	// Least times round up, never below one cycle
	function automatic int tdl_cycles(input int ns);
		int r;
		r = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (r < 1) ? 1 : r;
	endfunction

	localparam int HIGH_DLY_CYC = tdl_cycles(HIGH_TURN_ON_DELAY_NS);
	localparam int LOW_DLY_CYC  = tdl_cycles(LOW_TURN_ON_DELAY_NS);
	localparam int BLANK_CYC    = tdl_cycles(ZERO_CURRENT_BLANK_TIME_NS)
	                            + tdl_cycles(DEBOUNCE_NS);
	localparam int CAL_CYC      = tdl_cycles(CAL_TIME_NS);

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          AXI_ADDR_W      = 8;
	localparam logic [7:0]  REG_CTRL_ADDR   = 8'h00;
	localparam logic [7:0]  REG_STATUS_ADDR = 8'h04;
	localparam int          CTRL_ENABLE_BIT = 0;
	localparam int          CTRL_CAL_BIT    = 1;
	localparam logic        CTRL_ENABLE_RST = 1'b1;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LVL_LOW  = 2'h0,
		LVL_MID  = 2'h1,
		LVL_HIGH = 2'h2,
		LVL_OPEN = 2'h3
	} tdl_level_type;

	// Gray along the continuous loop and along the zero-current path
	typedef enum logic [3:0] {
		ST_OFF      = 4'h0,
		ST_LS_WAIT  = 4'h1,
		ST_LS_DELAY = 4'h3,
		ST_LS_ON    = 4'h2,
		ST_HS_WAIT  = 4'h6,
		ST_HS_DELAY = 4'h7,
		ST_HS_ON    = 4'h5,
		ST_ZC_BLANK = 4'hB,
		ST_ZC_MON   = 4'hA,
		ST_ZC_DONE  = 4'h8
	} tdl_state_type;

	typedef struct packed {
		logic supply_lockout;
		logic low_switch_off;
		logic high_switch_off;
		logic zero_current_check;
		logic warn_temp_limit;
		logic warn_cooled;
		logic shutdown_temp_limit;
		logic shutdown_cooled;
	} tdl_qual_type;

	typedef struct packed {
		logic [3:0] state;
		logic       thermal_pin;
		logic       cal_busy;
		logic       shutdown;
		logic       warn;
		logic       zc_mode;
		logic       enabled;
		logic       low_gate;
		logic       high_gate;
	} tdl_status_type;

endpackage

// *** design/tdl_sync.sv ***
`timescale 1ns/1ps
module tdl_sync
	import tdl_pkg::*;
#(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// Data
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// First stage feeds only the second stage
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= i_d;
			sync_r <= meta_r;
		end
	end

	assign o_q = sync_r;

endmodule // tdl_sync

// *** design/tdl_timer.sv ***
`timescale 1ns/1ps
module tdl_timer
	import tdl_pkg::*;
(
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// Control
	input  wire logic             i_load,
	input  wire logic [TMR_W-1:0] i_count,
	// Status
	output logic                  o_busy,
	output logic                  o_done
);

	logic [TMR_W-1:0] cnt_r;
	logic             armed_r;

	// Reload always wins so a restart never sees a stale expiry
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_r   <= '0;
			armed_r <= 1'b0;
		end else if (i_load) begin
			cnt_r   <= i_count;
			armed_r <= 1'b1;
		end else if (cnt_r != '0) begin
			cnt_r   <= cnt_r - TMR_W'(1);
		end
	end

	assign o_busy = (cnt_r != '0);
	assign o_done = armed_r && (cnt_r == '0);

endmodule // tdl_timer

// *** design/tdl_gate_drive.sv ***
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tdl_gate_drive
	import tdl_pkg::*;
#(
	parameter int HIGH_CYC  = HIGH_DLY_CYC,
	parameter int LOW_CYC   = LOW_DLY_CYC,
	parameter int ZC_CYC    = BLANK_CYC,
	parameter int CALIB_CYC = CAL_CYC
) (
	// Clock and reset
	input  wire logic                  I_CLK,
	input  wire logic                  I_RST,
	// Power stage pins and qualifiers
	input  wire logic [1:0]            I_PWM_LEVEL,
	input  wire logic [1:0]            I_SKIP_LEVEL_N,
	input  wire logic                  I_DRIVE_ENABLE_N,
	input  wire tdl_qual_type          I_QUAL,
	input  wire logic                  I_THERMAL_WARN_N,
	// Gate commands and warning pin
	output logic                       O_HIGH_GATE,
	output logic                       O_LOW_GATE,
	output logic                       O_THERMAL_WARN_N,
	output logic                       O_THERMAL_WARN_N_OE_N,
	// AXI4-Lite write
	input  wire logic [AXI_ADDR_W-1:0] I_AWADDR,
	input  wire logic                  I_AWVALID,
	output logic                       O_AWREADY,
	input  wire logic [31:0]           I_WDATA,
	input  wire logic [3:0]            I_WSTRB,
	input  wire logic                  I_WVALID,
	output logic                       O_WREADY,
	output logic [1:0]                 O_BRESP,
	output logic                       O_BVALID,
	input  wire logic                  I_BREADY,
	// AXI4-Lite read
	input  wire logic [AXI_ADDR_W-1:0] I_ARADDR,
	input  wire logic                  I_ARVALID,
	output logic                       O_ARREADY,
	output logic [31:0]                O_RDATA,
	output logic [1:0]                 O_RRESP,
	output logic                       O_RVALID,
	input  wire logic                  I_RREADY
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int QW    = $bits(tdl_qual_type);
	localparam int PIN_W = 2 + 2 + 1 + 1 + QW;

	logic [PIN_W-1:0] pins_s;
	logic [1:0]       pwm_s;
	logic [1:0]       skip_s;
	logic             en_s;
	logic             therm_pin_s;
	tdl_qual_type     q_s;

	tdl_sync #(.W(PIN_W)) u_sync (
		.i_clk (I_CLK),
		.i_rst (I_RST),
		.i_d   ({I_PWM_LEVEL, I_SKIP_LEVEL_N, I_DRIVE_ENABLE_N, I_THERMAL_WARN_N, I_QUAL}),
		.o_q   (pins_s)
	);

	assign {pwm_s, skip_s, en_s, therm_pin_s, q_s} = pins_s;

	// ----------------------------------------------------------------
	// Input decoding
	// ----------------------------------------------------------------
	// Pull-up on skip
	function automatic tdl_level_type skip_decode(input logic [1:0] code);
		tdl_level_type l;
		l = tdl_level_type'(code);
		return (l == LVL_LOW) ? LVL_LOW : LVL_HIGH;
	endfunction

	tdl_level_type pwm_lvl_r;
	tdl_level_type pwm_lvl_nxt;
	tdl_level_type skip_eff;
	logic          skip_is_mid;
	logic          zc_mode;

	assign skip_eff    = skip_decode(skip_s);
	assign skip_is_mid = (tdl_level_type'(skip_s) == LVL_MID);
	assign zc_mode     = (skip_eff == LVL_HIGH);

	assign pwm_lvl_nxt = (tdl_level_type'(pwm_s) != LVL_OPEN) ? tdl_level_type'(pwm_s) :
	                     skip_is_mid ? LVL_MID : pwm_lvl_r;

	logic want_hs;
	logic want_ls;
	logic want_zc;
	logic want_off;

	assign want_hs  = (pwm_lvl_r == LVL_HIGH);
	assign want_ls  = (pwm_lvl_r == LVL_LOW);
	assign want_zc  = (pwm_lvl_r == LVL_MID) && zc_mode;
	assign want_off = (pwm_lvl_r == LVL_MID) && !zc_mode;

	// ----------------------------------------------------------------
	// Enable, calibration and thermal state
	// ----------------------------------------------------------------
	logic ctrl_en_r;
	logic cal_req;
	logic en_prev_r;
	logic en_rise;
	logic cal_busy;
	logic warn_r;
	logic shut_r;
	logic enabled;

	assign en_rise = en_s && !en_prev_r;

	tdl_timer u_cal (
		.i_clk   (I_CLK),
		.i_rst   (I_RST),
		.i_load  (en_rise || cal_req),
		.i_count (TMR_W'(CALIB_CYC)),
		.o_busy  (cal_busy),
		.o_done  ()
	);

	// Gates stay off while calibrating: the threshold is not yet trusted
	// Pull-down reads as disabled
	assign enabled = !q_s.supply_lockout && en_s && !shut_r && ctrl_en_r && !cal_busy;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			en_prev_r <= 1'b0;
			warn_r    <= 1'b0;
			shut_r    <= 1'b0;
			pwm_lvl_r <= LVL_MID;
		end else begin
			en_prev_r <= en_s;
			pwm_lvl_r <= pwm_lvl_nxt;
			warn_r    <= q_s.warn_temp_limit || (warn_r && !q_s.warn_cooled);
			shut_r    <= q_s.shutdown_temp_limit || (shut_r && !q_s.shutdown_cooled);
		end
	end

	assign O_THERMAL_WARN_N      = 1'b0;
	assign O_THERMAL_WARN_N_OE_N = !warn_r;

	// ----------------------------------------------------------------
	// Gate sequencer
	// ----------------------------------------------------------------
	tdl_state_type    state_r;
	tdl_state_type    state_nxt;
	logic             tmr_done;
	logic             tmr_load;
	logic [TMR_W-1:0] tmr_val;
	logic             high_gate_r;
	logic             low_gate_r;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF: begin
				if (want_hs)
					state_nxt = ST_HS_WAIT;
				else if (want_ls || want_zc)
					state_nxt = ST_LS_WAIT;
			end
			ST_HS_WAIT: begin
				if (!want_hs)
					state_nxt = ST_OFF;
				else if (q_s.low_switch_off)
					state_nxt = ST_HS_DELAY;
			end
			ST_HS_DELAY: begin
				if (!want_hs)
					state_nxt = ST_OFF;
				else if (tmr_done)
					state_nxt = ST_HS_ON;
			end
			ST_HS_ON: begin
				if (want_off)
					state_nxt = ST_OFF;
				else if (!want_hs)
					state_nxt = ST_LS_WAIT;
			end
			ST_LS_WAIT: begin
				if (want_hs)
					state_nxt = ST_HS_WAIT;
				else if (want_off)
					state_nxt = ST_OFF;
				else if (q_s.high_switch_off)
					state_nxt = ST_LS_DELAY;
			end
			ST_LS_DELAY: begin
				if (want_hs)
					state_nxt = ST_HS_WAIT;
				else if (want_off)
					state_nxt = ST_OFF;
				else if (tmr_done)
					state_nxt = want_ls ? ST_LS_ON : ST_ZC_BLANK;
			end
			ST_LS_ON: begin
				if (want_hs)
					state_nxt = ST_HS_WAIT;
				else if (want_off)
					state_nxt = ST_OFF;
				else if (want_zc)
					state_nxt = ST_ZC_BLANK;
			end
			ST_ZC_BLANK: begin
				if (want_hs)
					state_nxt = ST_HS_WAIT;
				else if (want_off)
					state_nxt = ST_OFF;
				else if (want_ls)
					state_nxt = ST_LS_ON;
				else if (tmr_done)
					state_nxt = ST_ZC_MON;
			end
			ST_ZC_MON: begin
				if (want_hs)
					state_nxt = ST_HS_WAIT;
				else if (want_off)
					state_nxt = ST_OFF;
				else if (want_ls)
					state_nxt = ST_LS_ON;
				else if (q_s.zero_current_check)
					state_nxt = ST_ZC_DONE;
			end
			ST_ZC_DONE: begin
				if (want_hs)
					state_nxt = ST_HS_WAIT;
				else if (want_ls)
					state_nxt = ST_LS_WAIT;
				else if (want_off)
					state_nxt = ST_OFF;
			end
			default: state_nxt = ST_OFF;
		endcase
		if (!enabled)
			state_nxt = ST_OFF;
	end

	assign tmr_load = (state_nxt != state_r) && ((state_nxt == ST_HS_DELAY) ||
	                  (state_nxt == ST_LS_DELAY) || (state_nxt == ST_ZC_BLANK));
	assign tmr_val  = (state_nxt == ST_HS_DELAY) ? TMR_W'(HIGH_CYC) :
	                  (state_nxt == ST_LS_DELAY) ? TMR_W'(LOW_CYC) : TMR_W'(ZC_CYC);

	tdl_timer u_dly (
		.i_clk   (I_CLK),
		.i_rst   (I_RST),
		.i_load  (tmr_load),
		.i_count (tmr_val),
		.o_busy  (),
		.o_done  (tmr_done)
	);

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			state_r     <= ST_OFF;
			high_gate_r <= 1'b0;
			low_gate_r  <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			high_gate_r <= (state_nxt == ST_HS_ON);
			low_gate_r  <= (state_nxt == ST_LS_ON) || (state_nxt == ST_ZC_BLANK) ||
			               (state_nxt == ST_ZC_MON);
		end
	end

	assign O_HIGH_GATE = high_gate_r;
	assign O_LOW_GATE  = low_gate_r;

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic                  aw_got_r;
	logic                  w_got_r;
	logic [AXI_ADDR_W-1:0] awaddr_r;
	logic [31:0]           wdata_r;
	logic [3:0]            wstrb_r;
	logic                  bvalid_r;
	logic [1:0]            bresp_r;
	logic                  rvalid_r;
	logic [31:0]           rdata_r;
	logic [1:0]            rresp_r;
	logic                  aw_hs;
	logic                  w_hs;
	logic                  do_write;
	logic                  wr_ctrl;
	logic                  rd_ctrl;
	logic                  rd_stat;
	tdl_status_type        status;

	assign O_AWREADY = !aw_got_r && !bvalid_r;
	assign O_WREADY  = !w_got_r && !bvalid_r;
	assign O_ARREADY = !rvalid_r;
	assign aw_hs     = I_AWVALID && O_AWREADY;
	assign w_hs      = I_WVALID && O_WREADY;
	assign do_write  = aw_got_r && w_got_r;
	assign wr_ctrl   = do_write && (awaddr_r == REG_CTRL_ADDR);
	assign cal_req   = wr_ctrl && wstrb_r[0] && wdata_r[CTRL_CAL_BIT];
	assign rd_ctrl   = (I_ARADDR == REG_CTRL_ADDR);
	assign rd_stat   = (I_ARADDR == REG_STATUS_ADDR);

	assign status = '{state: state_r, thermal_pin: therm_pin_s, cal_busy: cal_busy,
	                  shutdown: shut_r, warn: warn_r, zc_mode: zc_mode, enabled: enabled,
	                  low_gate: low_gate_r, high_gate: high_gate_r};

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= '0;
			wstrb_r   <= '0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
			ctrl_en_r <= CTRL_ENABLE_RST;
		end else begin
			if (aw_hs) begin
				aw_got_r <= 1'b1;
				awaddr_r <= I_AWADDR;
			end
			if (w_hs) begin
				w_got_r <= 1'b1;
				wdata_r <= I_WDATA;
				wstrb_r <= I_WSTRB;
			end
			if (do_write) begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r  <= (wr_ctrl || awaddr_r == REG_STATUS_ADDR) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_r && I_BREADY) begin
				bvalid_r <= 1'b0;
			end
			if (wr_ctrl && wstrb_r[0])
				ctrl_en_r <= wdata_r[CTRL_ENABLE_BIT];
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= RESP_OKAY;
		end else if (I_ARVALID && O_ARREADY) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_ctrl ? 32'(ctrl_en_r) : rd_stat ? 32'(status) : 32'h0000_0000;
			rresp_r  <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_r && I_RREADY) begin
			rvalid_r <= 1'b0;
		end
	end

	assign O_BVALID = bvalid_r;
	assign O_BRESP  = bresp_r;
	assign O_RVALID = rvalid_r;
	assign O_RDATA  = rdata_r;
	assign O_RRESP  = rresp_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	no_overlap_a: assert property (!(high_gate_r && low_gate_r))
		else $error("both gates on");
	hs_after_delay_a: assert property ($rose(high_gate_r) |->
		$past(state_r) == ST_HS_DELAY && !$past(low_gate_r))
		else $error("high gate rose without delay");
	ls_after_delay_a: assert property ($rose(low_gate_r) |->
		$past(state_r) == ST_LS_DELAY && !$past(high_gate_r))
		else $error("low gate rose without delay");
	zc_blank_end_a: assert property (state_r == ST_ZC_BLANK && tmr_done && want_zc
		&& enabled |=> state_r == ST_ZC_MON && low_gate_r)
		else $error("blank end not honoured");
	zc_early_ign_a: assert property (state_r == ST_ZC_BLANK && !tmr_done && want_zc
		&& enabled |=> low_gate_r)
		else $error("early zero current acted on");
	zc_release_a: assert property (state_r == ST_ZC_MON && q_s.zero_current_check
		&& want_zc && enabled |=> !low_gate_r)
		else $error("zero current did not release gate");
	skip_low_off_a: assert property (want_off |=> !high_gate_r && !low_gate_r)
		else $error("mid with skip low left a gate on");
	disabled_off_a: assert property (!enabled |=> !high_gate_r && !low_gate_r)
		else $error("gate on while disabled");
	cal_start_a: assert property ($rose(en_s) |=> cal_busy[*8])
		else $error("calibration did not start");
	warn_pin_a: assert property (q_s.warn_temp_limit |=> !O_THERMAL_WARN_N_OE_N)
		else $error("warning pin not pulled");
	mode_sel_a: assert property (zc_mode == (tdl_level_type'(skip_s) != LVL_LOW))
		else $error("mode select wrong");

	hs_on_c: cover property ($rose(high_gate_r));
	zc_done_c: cover property (state_r == ST_ZC_MON ##1 state_r == ST_ZC_DONE);
	cal_end_c: cover property ($fell(cal_busy));

endmodule // tdl_gate_drive

// *** dv/tdl_ctrl_model.sv ***
`timescale 1ns/1ps
module tdl_ctrl_model
	import tdl_pkg::*;
(
	// Clock
	input  wire logic    i_clk,
	// Gate commands seen by the power stage
	input  wire logic    i_high_gate,
	input  wire logic    i_low_gate,
	// Controller pins and switch feedback
	output tdl_level_type o_pwm,
	output tdl_level_type o_skip,
	output logic          o_low_off,
	output logic          o_high_off
);
	int lag = 1;
	int lo_cnt = 15;
	int hi_cnt = 15;

	initial begin
		o_pwm = LVL_MID;
		o_skip = LVL_HIGH;
	end

	// Switches report off only after the gate has been low for lag cycles
	always @(posedge i_clk) begin
		lo_cnt <= i_low_gate ? 0 : ((lo_cnt < 15) ? lo_cnt + 1 : lo_cnt);
		hi_cnt <= i_high_gate ? 0 : ((hi_cnt < 15) ? hi_cnt + 1 : hi_cnt);
	end
	assign o_low_off = (lo_cnt >= lag);
	assign o_high_off = (hi_cnt >= lag);

	task automatic drive_pwm(input tdl_level_type l);
		o_pwm <= l;
	endtask

	task automatic drive_skip(input tdl_level_type l);
		o_skip <= l;
	endtask

	task automatic set_lag(input int n);
		lag = n;
	endtask
endmodule // tdl_ctrl_model

// *** dv/test_tristate_gate_drive_logic.sv ***
`timescale 1ns/1ps
module test_tristate_gate_drive_logic
	import tdl_pkg::*;
;
	localparam int CAL = 20;
	logic          clk = 1'h0;
	logic          rst = 1'h1;
	logic          en_n = 1'h0;
	tdl_qual_type  qset = 8'h00;
	tdl_qual_type  qual;
	tdl_level_type pwm;
	tdl_level_type skip;
	logic          lo_off, hi_off, hg, lg, wn, oe_n;
	logic [7:0]    awaddr = 8'h00;
	logic [7:0]    araddr = 8'h00;
	logic [31:0]   wdata = 32'h0;
	logic          awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic          awready, wready, bvalid, arready, rvalid;
	logic [1:0]    bresp, rresp;
	logic [31:0]   rdata, d;
	logic [1:0]    r;
	int            fails = 0;
	int            checks = 0;

	always #12.5 clk = ~clk;
	assign qual = {qset[7], lo_off, hi_off, qset[4:0]};

	tdl_gate_drive #(.CALIB_CYC(CAL)) uut (.I_CLK(clk), .I_RST(rst), .I_PWM_LEVEL(pwm),
		.I_SKIP_LEVEL_N(skip), .I_DRIVE_ENABLE_N(en_n), .I_QUAL(qual),
		.I_THERMAL_WARN_N(oe_n ? 1'h1 : wn), .O_HIGH_GATE(hg), .O_LOW_GATE(lg),
		.O_THERMAL_WARN_N(wn), .O_THERMAL_WARN_N_OE_N(oe_n), .I_AWADDR(awaddr),
		.I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF),
		.I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
		.I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready));

	tdl_ctrl_model cm (.i_clk(clk), .i_high_gate(hg), .i_low_gate(lg), .o_pwm(pwm),
		.o_skip(skip), .o_low_off(lo_off), .o_high_off(hi_off));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic conclude;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Ready is registered-driven, so its value at the negedge is what the edge samples
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw, w;
		aw = 1'h0;
		w = 1'h0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(aw && w)) begin
			@(negedge clk);
			aw = aw | awready;
			w = w | wready;
			@(posedge clk);
			if (aw) awvalid <= 1'h0;
			if (w) wvalid <= 1'h0;
		end
		do @(negedge clk); while (!bvalid);
		rs = bresp;
		@(posedge clk);
		bready <= 1'h0;
		// Let an edge pass so a following call never re-drives bready in this step
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arvalid <= 1'h0;
		do @(negedge clk); while (!rvalid);
		v = rdata;
		rs = rresp;
		@(posedge clk);
		rready <= 1'h0;
		@(posedge clk);
	endtask

	task automatic gates(input logic h, input logic l, input int n);
		for (int i = 0; i < n && {hg, lg} !== {h, l}; i++)
			@(negedge clk);
		chk("gates", {hg, lg}, {h, l});
		@(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_enable;
		cm.drive_pwm(LVL_HIGH);
		cyc(10);
		gates(1'h0, 1'h0, 1);
		en_n <= 1'h1;
		cyc(4);
		rd(REG_STATUS_ADDR, d, r);
		chk("cal_busy", d[6], 1'h1);
		chk("cal_gates", d[1:0], 2'h0);
		gates(1'h1, 1'h0, CAL + 20);
	endtask

	task automatic t_cont;
		cm.drive_pwm(LVL_LOW);
		gates(1'h0, 1'h1, 20);
		cm.drive_pwm(LVL_HIGH);
		gates(1'h1, 1'h0, 20);
		// Slow switches: the other gate must wait for the off report
		cm.set_lag(8);
		cm.drive_pwm(LVL_LOW);
		cyc(8);
		chk("slow_fall", {hg, lg}, 2'h0);
		gates(1'h0, 1'h1, 20);
		cm.drive_pwm(LVL_HIGH);
		cyc(8);
		chk("slow_rise", {hg, lg}, 2'h0);
		gates(1'h1, 1'h0, 20);
		cm.set_lag(1);
	endtask

	task automatic t_zc(input tdl_level_type s);
		cm.drive_skip(s);
		cm.drive_pwm(LVL_HIGH);
		gates(1'h1, 1'h0, 20);
		cm.drive_pwm(LVL_MID);
		gates(1'h0, 1'h1, 20);
		qset.zero_current_check <= 1'h1;
		cyc(8);
		chk("zc_early", lg, 1'h1);
		gates(1'h0, 1'h0, 20);
		qset.zero_current_check <= 1'h0;
	endtask

	task automatic t_modes;
		cm.drive_skip(LVL_MID);
		cm.drive_pwm(LVL_HIGH);
		gates(1'h1, 1'h0, 20);
		cm.drive_pwm(LVL_OPEN);
		gates(1'h0, 1'h1, 20);
		cm.drive_skip(LVL_LOW);
		cm.drive_pwm(LVL_HIGH);
		gates(1'h1, 1'h0, 20);
		cm.drive_pwm(LVL_MID);
		gates(1'h0, 1'h0, 6);
		cyc(10);
		chk("skip_low_mid", {hg, lg}, 2'h0);
		cm.drive_skip(LVL_HIGH);
		cm.drive_pwm(LVL_HIGH);
		gates(1'h1, 1'h0, 20);
		qset.supply_lockout <= 1'h1;
		gates(1'h0, 1'h0, 6);
		qset.supply_lockout <= 1'h0;
		gates(1'h1, 1'h0, 20);
	endtask

	task automatic t_thermal;
		qset.warn_temp_limit <= 1'h1;
		cyc(6);
		chk("warn_on", oe_n, 1'h0);
		chk("warn_run", {hg, lg}, 2'h2);
		rd(REG_STATUS_ADDR, d, r);
		chk("warn_pin", d[7], 1'h0);
		chk("warn_wire", wn, 1'h0);
		qset.warn_temp_limit <= 1'h0;
		cyc(4);
		chk("warn_hold", oe_n, 1'h0);
		qset.warn_cooled <= 1'h1;
		cyc(6);
		chk("warn_off", oe_n, 1'h1);
		qset.warn_cooled <= 1'h0;
		qset.shutdown_temp_limit <= 1'h1;
		gates(1'h0, 1'h0, 6);
		qset.shutdown_temp_limit <= 1'h0;
		cyc(4);
		chk("shut_hold", {hg, lg}, 2'h0);
		qset.shutdown_cooled <= 1'h1;
		gates(1'h1, 1'h0, 20);
		qset.shutdown_cooled <= 1'h0;
	endtask

	task automatic t_regs;
		rd(REG_CTRL_ADDR, d, r);
		chk("ctrl_rst", d, 32'h1);
		wr(REG_CTRL_ADDR, 32'h0, r);
		chk("wr_okay", r, RESP_OKAY);
		gates(1'h0, 1'h0, 6);
		wr(REG_STATUS_ADDR, 32'hF, r);
		chk("wr_ro", r, RESP_OKAY);
		rd(8'h40, d, r);
		chk("rd_bad", {d, r}, {32'h0, RESP_SLVERR});
		wr(8'h40, 32'h0, r);
		chk("wr_bad", r, RESP_SLVERR);
		wr(REG_CTRL_ADDR, 32'h1, r);
		gates(1'h1, 1'h0, 20);
		// Software-started calibration holds the gates off until it ends
		wr(REG_CTRL_ADDR, 32'h3, r);
		rd(REG_STATUS_ADDR, d, r);
		chk("swcal_busy", d[6], 1'h1);
		chk("swcal_gates", d[1:0], 2'h0);
		rd(REG_CTRL_ADDR, d, r);
		chk("swcal_ctrl", d, 32'h1);
		gates(1'h1, 1'h0, CAL + 20);
	endtask

	initial begin
		#200000;
		fails++;
		conclude();
	end

	initial begin
		cyc(3);
		rst <= 1'h0;
		cyc(1);
		chk("rst_warn", oe_n, 1'h1);
		t_enable();
		t_cont();
		t_zc(LVL_HIGH);
		t_zc(LVL_MID);
		t_zc(LVL_OPEN);
		t_modes();
		t_thermal();
		t_regs();
		conclude();
	end
endmodule // test_tristate_gate_drive_logic
